//--- verilog/event_enable_pkg.sv
`default_nettype none
package event_enable_pkg;

    // ==================================================================
    // Widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int EVENT_N = 64;
    localparam int DEC_W = 5;

    // ==================================================================
    // Register byte offsets (one aligned word each)
    localparam logic [DEC_W-1:0] OFF_MASK_LOW = 5'h00;
    localparam logic [DEC_W-1:0] OFF_MASK_HIGH = 5'h04;
    localparam logic [DEC_W-1:0] OFF_CLEAR_LOW = 5'h08;
    localparam logic [DEC_W-1:0] OFF_CLEAR_HIGH = 5'h0c;
    localparam logic [DEC_W-1:0] OFF_SET_LOW = 5'h10;
    localparam logic [DEC_W-1:0] OFF_SET_HIGH = 5'h14;

    // ==================================================================
    // Reset values and bus codes
    localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // ==================================================================
    // Register selection
    typedef enum {
        SEL_NONE,
        SEL_MASK_LOW,
        SEL_MASK_HIGH,
        SEL_CLEAR_LOW,
        SEL_CLEAR_HIGH,
        SEL_SET_LOW,
        SEL_SET_HIGH
    } reg_sel_t;

endpackage
`default_nettype wire

//--- verilog/event_enable_set_clear_bank.sv
`timescale 1ns/1ps
`default_nettype none
module event_enable_set_clear_bank
    import event_enable_pkg::*;
#(
    parameter int EVENTS = EVENT_N
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Event sources
    input wire logic [EVENTS-1:0] eventLatch,
    input wire logic [EVENTS-1:0] chainedEvent,
    input wire logic [EVENTS-1:0] manualEvent,
    // Mask and evaluation
    output logic [EVENTS-1:0] enableMask,
    output logic [EVENTS-1:0] eventEvaluate
);

    // ==================================================================
    // Address decode
    function automatic reg_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[ADDR_W-1:DEC_W] == '0)
        begin
            case (addr[DEC_W-1:0])
                OFF_MASK_LOW: sel = SEL_MASK_LOW;
                OFF_MASK_HIGH: sel = SEL_MASK_HIGH;
                OFF_CLEAR_LOW: sel = SEL_CLEAR_LOW;
                OFF_CLEAR_HIGH: sel = SEL_CLEAR_HIGH;
                OFF_SET_LOW: sel = SEL_SET_LOW;
                OFF_SET_HIGH: sel = SEL_SET_HIGH;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // ==================================================================
    // State
    logic [DATA_W-1:0] enableMaskLow;
    logic [DATA_W-1:0] enableMaskHigh;
    logic wrValid;
    reg_sel_t wrSel;
    logic [DATA_W-1:0] next_enableMaskLow;
    logic [DATA_W-1:0] next_enableMaskHigh;
    logic next_wrValid;
    reg_sel_t next_wrSel;
    logic [DATA_W-1:0] next_hrdata;
    logic [EVENTS-1:0] next_eventEvaluate;
    logic addrPhase;
    reg_sel_t addrSel;

    assign addrPhase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign addrSel = decodeSel(haddr);

    // ==================================================================
    // Next values
    always_comb
    begin
        next_enableMaskLow = enableMaskLow;
        next_enableMaskHigh = enableMaskHigh;
        // Writes land in the data phase; mask halves themselves ignore writes
        if (wrValid)
        begin
            case (wrSel)
                SEL_CLEAR_LOW: next_enableMaskLow = enableMaskLow & ~hwdata;
                SEL_CLEAR_HIGH: next_enableMaskHigh = enableMaskHigh & ~hwdata;
                SEL_SET_LOW: next_enableMaskLow = enableMaskLow | hwdata;
                SEL_SET_HIGH: next_enableMaskHigh = enableMaskHigh | hwdata;
                default: next_enableMaskLow = enableMaskLow;
            endcase
        end
        // Only size-agnostic single words; hsize is accepted as given
        next_wrValid = addrPhase && hwrite;
        next_wrSel = addrSel;
        // Read data uses the post-write mask so back-to-back write/read is coherent
        next_hrdata = READ_ZERO;
        if (addrPhase && !hwrite)
        begin
            case (addrSel)
                SEL_MASK_LOW: next_hrdata = next_enableMaskLow;
                SEL_MASK_HIGH: next_hrdata = next_enableMaskHigh;
                default: next_hrdata = READ_ZERO;
            endcase
        end
        // Latched events pending while disabled simply wait for the enable
        next_eventEvaluate = (eventLatch & {enableMaskHigh, enableMaskLow})
            | chainedEvent | manualEvent;
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            enableMaskLow <= MASK_RESET;
            enableMaskHigh <= MASK_RESET;
            wrValid <= 1'b0;
            wrSel <= SEL_NONE;
            hrdata <= READ_ZERO;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            enableMask <= '0;
            eventEvaluate <= '0;
        end
        else
        begin
            enableMaskLow <= next_enableMaskLow;
            enableMaskHigh <= next_enableMaskHigh;
            wrValid <= next_wrValid;
            wrSel <= next_wrSel;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            enableMask <= {next_enableMaskHigh, next_enableMaskLow};
            eventEvaluate <= next_eventEvaluate;
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence seqClearLow;
        wrValid && wrSel == SEL_CLEAR_LOW;
    endsequence
    sequence seqClearHigh;
        wrValid && wrSel == SEL_CLEAR_HIGH;
    endsequence
    sequence seqSetLow;
        wrValid && wrSel == SEL_SET_LOW;
    endsequence
    sequence seqSetHigh;
        wrValid && wrSel == SEL_SET_HIGH;
    endsequence
    sequence seqWoRead;
        addrPhase && !hwrite && (addrSel == SEL_CLEAR_LOW || addrSel == SEL_CLEAR_HIGH
            || addrSel == SEL_SET_LOW || addrSel == SEL_SET_HIGH);
    endsequence

    a_clear_low: assert property (seqClearLow |=>
        enableMaskLow == ($past(enableMaskLow) & ~$past(hwdata))
        && enableMaskHigh == $past(enableMaskHigh))
        else $error("low clear write did not clear mask bits");
    a_clear_high: assert property (seqClearHigh |=>
        enableMaskHigh == ($past(enableMaskHigh) & ~$past(hwdata))
        && enableMaskLow == $past(enableMaskLow))
        else $error("high clear write did not clear mask bits");
    a_set_low: assert property (seqSetLow |=>
        enableMaskLow == ($past(enableMaskLow) | $past(hwdata))
        && enableMaskHigh == $past(enableMaskHigh))
        else $error("low set write did not set mask bits");
    a_set_high: assert property (seqSetHigh |=>
        enableMaskHigh == ($past(enableMaskHigh) | $past(hwdata))
        && enableMaskLow == $past(enableMaskLow))
        else $error("high set write did not set mask bits");
    a_zero_no_effect: assert property (wrValid |=>
        (((enableMaskLow ^ $past(enableMaskLow))
        | (enableMaskHigh ^ $past(enableMaskHigh))) & ~$past(hwdata)) == '0)
        else $error("zero bit of a write changed the mask");
    a_mask_write_only: assert property (!(wrValid && wrSel inside {SEL_CLEAR_LOW,
        SEL_CLEAR_HIGH, SEL_SET_LOW, SEL_SET_HIGH}) |=>
        $stable(enableMaskLow) && $stable(enableMaskHigh))
        else $error("mask changed without a set or clear write");
    a_wo_read_zero: assert property (seqWoRead |=> hrdata == READ_ZERO)
        else $error("write-only register read back nonzero");
    a_mask_out_match: assert property (##1 enableMask == {enableMaskHigh, enableMaskLow})
        else $error("mask output disagrees with mask state");
    a_eval_gate: assert property (##1 eventEvaluate == (($past(eventLatch)
        & $past(enableMask)) | $past(chainedEvent) | $past(manualEvent)))
        else $error("event evaluation not gated by mask");
    a_chain_bypass: assert property ((chainedEvent | manualEvent) != '0 |=>
        (eventEvaluate & $past(chainedEvent | manualEvent)) == $past(chainedEvent | manualEvent))
        else $error("chained or manual event was masked");
    a_response_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("slave stalled or answered with an error");

    // ==================================================================
    // Read-back and pending events
    a_read_mask_low: assert property (addrPhase && !hwrite && addrSel == SEL_MASK_LOW |=>
        hrdata == enableMaskLow)
        else $error("mask low read returned wrong data");
    a_read_mask_high: assert property (addrPhase && !hwrite && addrSel == SEL_MASK_HIGH |=>
        hrdata == enableMaskHigh)
        else $error("mask high read returned wrong data");
    a_read_idle_zero: assert property (!(addrPhase && !hwrite) |=>
        hrdata == READ_ZERO)
        else $error("read data did not return to zero");
    a_read_no_alter: assert property (addrPhase && !hwrite && !wrValid |=>
        $stable(enableMaskLow) && $stable(enableMaskHigh))
        else $error("read changed the mask");
    a_disabled_held: assert property (##1
        (eventEvaluate & ~$past(chainedEvent | manualEvent) & ~$past(enableMask)) == '0)
        else $error("disabled latched event was evaluated");

endmodule
`default_nettype wire

//--- tb/event_enable_set_clear_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module event_enable_set_clear_bank_tb
    import event_enable_pkg::*;
;
    // ==========================================================
    // Signals
    logic clock, rstn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [ADDR_W-1:0] haddr;
    logic [DATA_W-1:0] hwdata, hrdata, lfsr, pick;
    logic [EVENT_N-1:0] eventLatch, chainedEvent, manualEvent, enableMask, eventEvaluate;
    logic [EVENT_N-1:0] expMask;
    logic [4:0] offs [7];
    int error_cnt, total_checks, cycles;

    event_enable_set_clear_bank u_dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eventLatch(eventLatch),
        .chainedEvent(chainedEvent), .manualEvent(manualEvent), .enableMask(enableMask),
        .eventEvaluate(eventEvaluate));

    // ==========================================================
    // Expectation and checking
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [63:0] applyWrite(input logic [63:0] m, input logic [4:0] a,
        input logic [31:0] d);
        logic [63:0] r;
        r = m;
        case (a)
            OFF_CLEAR_LOW: r[31:0] = m[31:0] & ~d;
            OFF_CLEAR_HIGH: r[63:32] = m[63:32] & ~d;
            OFF_SET_LOW: r[31:0] = m[31:0] | d;
            OFF_SET_HIGH: r[63:32] = m[63:32] | d;
            default: r = m;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] readExp(input logic [63:0] m, input logic [4:0] a);
        if (a == OFF_MASK_LOW)
            return m[31:0];
        if (a == OFF_MASK_HIGH)
            return m[63:32];
        return 32'h0;
    endfunction

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // ==========================================================
    // Bus master: one address phase, one data phase
    task automatic doOp(input logic [4:0] a, input logic w, input logic [31:0] d);
        logic [31:0] q;
        @(posedge clock);
        haddr <= {27'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        if (w)
            expMask = applyWrite(expMask, a, d);
        else
            chk("read data", {32'h0, readExp(expMask, a)}, {32'h0, q});
        #1;
        chk("enable mask", expMask, enableMask);
        chk("response", 64'h0, {63'h0, hresp});
    endtask

    // Events held two edges so the one-cycle lag settles
    task automatic evCheck();
        @(posedge clock);
        eventLatch <= {rnd(), rnd()};
        chainedEvent <= {rnd() & rnd(), rnd() & rnd()};
        manualEvent <= {rnd() & rnd(), rnd() & rnd()};
        repeat (2) @(posedge clock);
        #1;
        chk("event evaluate",
            (eventLatch & expMask) | chainedEvent | manualEvent, eventEvaluate);
    endtask

    // Write then read with no idle cycle between; the read must see the write
    task automatic doPair(input logic [4:0] wa, input logic [31:0] d, input logic [4:0] ra);
        logic [31:0] q;
        @(posedge clock);
        haddr <= {27'h0, wa};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        do @(posedge clock); while (hreadyout !== 1'b1);
        haddr <= {27'h0, ra};
        hwrite <= 1'b0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        expMask = applyWrite(expMask, wa, d);
        chk("read after write", {32'h0, readExp(expMask, ra)}, {32'h0, q});
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Clock, timeout and main sequence
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    initial
    begin
        rstn = 1'b0;
        hsel = 1'b1;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        eventLatch = '0;
        chainedEvent = '0;
        manualEvent = '0;
        expMask = '0;
        lfsr = 32'h1645;
        offs = '{OFF_MASK_LOW, OFF_MASK_HIGH, OFF_CLEAR_LOW, OFF_CLEAR_HIGH, OFF_SET_LOW,
            OFF_SET_HIGH, 5'h18};
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++)
            doOp(offs[i], 1'b0, 32'h0);
        evCheck();
        doOp(OFF_SET_LOW, 1'b1, 32'hffff_ffff);
        doOp(OFF_SET_HIGH, 1'b1, 32'h8000_0001);
        doOp(OFF_MASK_LOW, 1'b1, 32'h0);
        doOp(OFF_MASK_HIGH, 1'b1, 32'h0);
        doOp(5'h18, 1'b1, 32'h0);
        doOp(OFF_CLEAR_LOW, 1'b1, 32'h0);
        doOp(OFF_CLEAR_HIGH, 1'b1, 32'h8000_0000);
        doOp(OFF_CLEAR_LOW, 1'b1, 32'h0000_0001);
        doPair(OFF_SET_HIGH, 32'h0000_0100, OFF_MASK_HIGH);
        doPair(OFF_CLEAR_HIGH, 32'h0000_0100, OFF_MASK_HIGH);
        for (int i = 0; i < 200; i++)
        begin
            pick = rnd();
            doOp(offs[pick % 7], pick[8], rnd());
            evCheck();
        end
        close_out();
    end
endmodule
`default_nettype wire
